// file: src/dblc_params.svh
// offsets, field positions, reset values and bus answers of the drop bus pin mux
`ifndef DBLC_PARAMS_SVH
`define DBLC_PARAMS_SVH

// register indexes, byte address is four times the index
`define DBLC_IDX_IND_PAGE      16'h0000
`define DBLC_IDX_IND_OFFSET    16'h0001
`define DBLC_IDX_IND_DATA      16'h0002
`define DBLC_IDX_BUS_CTRL      16'h0003
`define DBLC_IDX_LINE_MODE     16'h0004
`define DBLC_IDX_STATUS        16'h0005
`define DBLC_IDX_IO_CTRL_CH1   16'h2f01
`define DBLC_IDX_IO_CTRL_CH5   16'h6f01

// indirect page and offset pairs
`define DBLC_PAGE_CH1          8'h2e
`define DBLC_PAGE_CH5          8'h6e
`define DBLC_PAGE_OFS_IO       8'h01

// field positions
`define DBLC_BIT_CLK_INVERT    0
`define DBLC_BIT_BUS_ENABLE    0
`define DBLC_MODE_CH1_LSB      0
`define DBLC_MODE_CH5_LSB      2
`define DBLC_STAT_BUS_ENABLE   0
`define DBLC_STAT_INV_CH1      1
`define DBLC_STAT_INV_CH5      2

// reset values
`define DBLC_RST_BYTE          8'h00
`define DBLC_RST_MODE          4'h0

// bus answers
`define DBLC_RESP_OKAY         2'b00
`define DBLC_RESP_DECODE_ERR   2'b11

`endif

// file: src/dblc_pkg.sv
// types shared by the drop bus pin mux modules
package dblc_pkg;

   // line rate of a channel, gray coded
   typedef enum logic [1:0] {
      DBLC_MODE_DS3  = 2'b00,
      DBLC_MODE_E3   = 2'b01,
      DBLC_MODE_STS1 = 2'b11
   } dblc_line_mode_t;

   // register targets of one bus access
   typedef enum logic [3:0] {
      DBLC_SEL_NONE   = 4'h0,
      DBLC_SEL_PAGE   = 4'h1,
      DBLC_SEL_OFFSET = 4'h2,
      DBLC_SEL_DATA   = 4'h3,
      DBLC_SEL_BUS    = 4'h4,
      DBLC_SEL_MODE   = 4'h5,
      DBLC_SEL_STATUS = 4'h6,
      DBLC_SEL_IO1    = 4'h7,
      DBLC_SEL_IO5    = 4'h8
   } dblc_sel_t;

endpackage

// file: src/dblc_line_tx.sv
// line clock generator and line data retimer for one channel
`timescale 1ns/10ps

module dblc_line_tx
   import dblc_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic active_i,
   input  wire logic invert_i,
   input  wire logic data_i,
   output logic      next_clk_o,
   output logic      line_clk_o,
   output logic      line_data_o
);

   logic rise;
   logic fall;

   // half rate of the link clock; held low while the pins carry the drop bus
   always_comb begin
      next_clk_o = active_i ? ~line_clk_o : 1'b0;
      rise       = ~line_clk_o & next_clk_o;
      fall       = line_clk_o & ~next_clk_o & active_i;
   end

   // line clock flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_clk_o <= 1'b0;
      end else begin
         line_clk_o <= next_clk_o;
      end
   end

   // data moves on the chosen edge of the line clock
   always_ff @(posedge clk_i) begin
      if (rst_i || !active_i) begin
         line_data_o <= 1'b0;
      end else if (invert_i ? fall : rise) begin
         line_data_o <= data_i;
      end
   end

endmodule // dblc_line_tx

// file: src/dblc_pin_mux.sv
// shared drop bus data / line clock pins with register slave
//
// Summary of operation
// - bus enable picks drop data or line clock for both shared pins.
// - enabled bus drives byte bits 5 and 6, changing on the bus clock rise.
// - disabled bus gives channel 1 and channel 5 line rate clocks.
// - line data normally changes on the rising line clock edge.
// - in DS3 or E3, invert bit 0 moves data change to the falling edge.
// - in STS-1 the data always changes on the rising edge.
// - each I/O control register is reached by page/offset and directly.
// - byte bit 7 is the most significant bit of the drop bus.
`timescale 1ns/10ps
`include "dblc_params.svh"

module dblc_pin_mux
   import dblc_pkg::*;
#(
   parameter int ADDR_W = 18,
   parameter int SYNC_W = 3
)
(
   input  wire logic              REF_CLK_I,
   input  wire logic              SYS_RST_I,
   input  wire logic              LINK_CLK_I,
   input  wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
   input  wire logic              AVS_READ_I,
   input  wire logic              AVS_WRITE_I,
   input  wire logic [31:0]       AVS_WRITEDATA_I,
   input  wire logic [3:0]        AVS_BYTEENABLE_I,
   output logic      [31:0]       AVS_READDATA_O,
   output logic                   AVS_WAITREQUEST_O,
   output logic      [1:0]        AVS_RESPONSE_O,
   input  wire logic [7:0]        DROP_BUS_DATA_CH1_I,
   input  wire logic              LINE_DATA_CH1_I,
   input  wire logic              LINE_DATA_CH5_I,
   output logic                   DROP_BUS_DATA_BIT5_O,
   output logic                   DROP_BUS_DATA_BIT6_O,
   output logic                   LINE_DATA_OUT_CH1_O,
   output logic                   LINE_DATA_OUT_CH5_O
);

   // register state; mode codes and I/O control bytes are kept whole, so
   // software reads back what it wrote, invert bits included even in STS-1
   logic [7:0]      ind_page;
   logic [7:0]      ind_offset;
   logic            bus_enable;
   logic [3:0]      line_mode;
   logic [7:0]      line_io_control_ch1;
   logic [7:0]      line_io_control_ch5;
   logic [2:0]      cfg;

   // bus slave state
   logic            req;
   logic [15:0]     acc_index;
   dblc_sel_t       acc_sel;
   dblc_sel_t       next_sel;
   logic [7:0]      next_rdata;

   // crossing state
   logic [SYNC_W-1:0] cfg_meta;
   logic [SYNC_W-1:0] cfg_link;
   logic            link_rst_meta;
   logic            link_rst;
   logic            stat_meta;
   logic            stat_bus;

   // link side
   logic            link_bus_en;
   logic            line_active;
   logic [1:0]      next_line_clk;
   logic [1:0]      line_clk;
   logic [1:0]      line_data;
   logic [1:0]      line_in;
   logic [1:0]      line_inv;

   // register map, one 8-bit register in the low byte of each word:
   //   index 0x0000  indirect page select
   //   index 0x0001  indirect offset select
   //   index 0x0002  indirect data, lands on whatever page and offset name
   //   index 0x0003  drop bus enable in bit 0
   //   index 0x0004  line rate, two bits per channel, ch1 low, ch5 above
   //   index 0x0005  status, read only: bus enable as the link side sees it,
   //                 then the invert actually in force for ch1 and ch5
   //   index 0x2f01  ch1 line I/O control, bit 0 clock invert
   //   index 0x6f01  ch5 line I/O control, bit 0 clock invert
   // anything else answers with a decode error and reads as zero; an unknown
   // page and offset pair behind the indirect data word does the same

   // direct index to register target
   function automatic dblc_sel_t dblc_decode_index(input logic [15:0] idx);
      dblc_sel_t s;
      s = DBLC_SEL_NONE;
      case (idx)
         `DBLC_IDX_IND_PAGE: begin
            s = DBLC_SEL_PAGE;
         end
         `DBLC_IDX_IND_OFFSET: begin
            s = DBLC_SEL_OFFSET;
         end
         `DBLC_IDX_IND_DATA: begin
            s = DBLC_SEL_DATA;
         end
         `DBLC_IDX_BUS_CTRL: begin
            s = DBLC_SEL_BUS;
         end
         `DBLC_IDX_LINE_MODE: begin
            s = DBLC_SEL_MODE;
         end
         `DBLC_IDX_STATUS: begin
            s = DBLC_SEL_STATUS;
         end
         `DBLC_IDX_IO_CTRL_CH1: begin
            s = DBLC_SEL_IO1;
         end
         `DBLC_IDX_IO_CTRL_CH5: begin
            s = DBLC_SEL_IO5;
         end
         default: begin
            s = DBLC_SEL_NONE;
         end
      endcase
      return s;
   endfunction

   // page and offset pair to register target
   function automatic dblc_sel_t dblc_decode_page(input logic [7:0] page,
                                                   input logic [7:0] ofs);
      dblc_sel_t s;
      s = DBLC_SEL_NONE;
      if (ofs == `DBLC_PAGE_OFS_IO) begin
         if (page == `DBLC_PAGE_CH1) begin
            s = DBLC_SEL_IO1;
         end else if (page == `DBLC_PAGE_CH5) begin
            s = DBLC_SEL_IO5;
         end
      end
      return s;
   endfunction

   // invert only counts outside STS-1 operation; the spare code 10 is taken
   // as a non-STS-1 rate, so the invert bit still applies there
   function automatic logic dblc_eff_invert(input logic [7:0] io,
                                            input logic [1:0] mode);
      logic inv;
      inv = io[`DBLC_BIT_CLK_INVERT];
      if (mode == DBLC_MODE_STS1) begin
         inv = 1'b0;
      end
      return inv;
   endfunction

   assign req       = AVS_READ_I | AVS_WRITE_I;
   assign acc_index = 16'(AVS_ADDRESS_I[ADDR_W-1:2]);

   // target of the pending access, indirect data folds onto its target
   always_comb begin
      next_sel = dblc_decode_index(acc_index);
      if (next_sel == DBLC_SEL_DATA) begin
         next_sel = dblc_decode_page(ind_page, ind_offset);
      end
   end

   // read value of the pending access
   always_comb begin
      case (next_sel)
         DBLC_SEL_PAGE: begin
            next_rdata = ind_page;
         end
         DBLC_SEL_OFFSET: begin
            next_rdata = ind_offset;
         end
         DBLC_SEL_BUS: begin
            next_rdata = {7'h00, bus_enable};
         end
         DBLC_SEL_MODE: begin
            next_rdata = {4'h0, line_mode};
         end
         DBLC_SEL_STATUS: begin
            next_rdata = {5'h00, cfg[2:1], stat_bus};
         end
         DBLC_SEL_IO1: begin
            next_rdata = line_io_control_ch1;
         end
         DBLC_SEL_IO5: begin
            next_rdata = line_io_control_ch5;
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // one wait cycle per access, then a single cycle of completion;
   // waitrequest idles high so a request is never taken before its target
   // has been decoded and the answer registered, at the cost of one extra
   // cycle on every access
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         AVS_WAITREQUEST_O <= 1'b1;
      end else begin
         AVS_WAITREQUEST_O <= ~(req & AVS_WAITREQUEST_O);
      end
   end

   // answer registered during the wait cycle
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         AVS_READDATA_O <= 32'h0000_0000;
         AVS_RESPONSE_O <= `DBLC_RESP_OKAY;
         acc_sel        <= DBLC_SEL_NONE;
      end else if (req && AVS_WAITREQUEST_O) begin
         AVS_READDATA_O <= {24'h00_0000, next_rdata};
         AVS_RESPONSE_O <= (next_sel == DBLC_SEL_NONE) ? `DBLC_RESP_DECODE_ERR
                                                       : `DBLC_RESP_OKAY;
         acc_sel        <= next_sel;
      end
   end

   // writes land on the completing edge; only the low byte lane is used;
   // writes with that lane off, or to unknown targets, are dropped while
   // the access itself still completes, with a decode error for unknown targets
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         ind_page            <= `DBLC_RST_BYTE;
         ind_offset          <= `DBLC_RST_BYTE;
         bus_enable          <= 1'b0;
         line_mode           <= `DBLC_RST_MODE;
         line_io_control_ch1 <= `DBLC_RST_BYTE;
         line_io_control_ch5 <= `DBLC_RST_BYTE;
      end else if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0]) begin
         case (acc_sel)
            DBLC_SEL_PAGE: begin
               ind_page <= AVS_WRITEDATA_I[7:0];
            end
            DBLC_SEL_OFFSET: begin
               ind_offset <= AVS_WRITEDATA_I[7:0];
            end
            DBLC_SEL_BUS: begin
               bus_enable <= AVS_WRITEDATA_I[`DBLC_BIT_BUS_ENABLE];
            end
            DBLC_SEL_MODE: begin
               line_mode <= AVS_WRITEDATA_I[3:0];
            end
            DBLC_SEL_IO1: begin
               line_io_control_ch1 <= AVS_WRITEDATA_I[7:0];
            end
            DBLC_SEL_IO5: begin
               line_io_control_ch5 <= AVS_WRITEDATA_I[7:0];
            end
            default: begin
               ind_page <= ind_page;
            end
         endcase
      end
   end

   // settings registered before crossing so the link side sees clean levels
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         cfg <= 3'h0;
      end else begin
         cfg[0] <= bus_enable;
         cfg[1] <= dblc_eff_invert(line_io_control_ch1,
                                   line_mode[`DBLC_MODE_CH1_LSB +: 2]);
         cfg[2] <= dblc_eff_invert(line_io_control_ch5,
                                   line_mode[`DBLC_MODE_CH5_LSB +: 2]);
      end
   end

   // reset release into the link domain; the link side leaves reset two
   // link edges late, so the pins stay low that long after release
   always_ff @(posedge LINK_CLK_I) begin
      link_rst_meta <= SYS_RST_I;
      link_rst      <= link_rst_meta;
   end

   // two-flop level crossing of each setting bit; bits are quasi-static,
   // so software must not expect two bits to switch on the same link edge
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_cfg_sync
         always_ff @(posedge LINK_CLK_I) begin
            cfg_meta[gi] <= cfg[gi];
            cfg_link[gi] <= cfg_meta[gi];
         end
      end
   endgenerate

   assign link_bus_en = cfg_link[`DBLC_BIT_BUS_ENABLE];
   assign line_active = ~link_bus_en & ~link_rst;
   assign line_in     = {LINE_DATA_CH5_I, LINE_DATA_CH1_I};
   assign line_inv    = cfg_link[2:1];

   // pin function as seen by the link, back to the register side; software
   // polls this copy to know when a new bus setting has taken hold
   always_ff @(posedge REF_CLK_I) begin
      stat_meta <= link_bus_en;
      stat_bus  <= stat_meta;
   end

   // one line clock and retimer per channel, ch1 then ch5; both share the
   // link clock and its reset, each has its own invert
   generate
      for (gi = 0; gi < 2; gi++) begin : g_line
         dblc_line_tx u_line (
            .clk_i       (LINK_CLK_I),
            .rst_i       (link_rst),
            .active_i    (line_active),
            .invert_i    (line_inv[gi]),
            .data_i      (line_in[gi]),
            .next_clk_o  (next_line_clk[gi]),
            .line_clk_o  (line_clk[gi]),
            .line_data_o (line_data[gi])
         );
      end
   endgenerate

   // shared pins: bus data taken on the bus clock rise, else line clocks;
   // the clock pin loads the same next value as the retimer's clock flop,
   // so pin and retimer never drift apart by a cycle; except on the first link edge
   // after a bus enable change, the data pin moves on an edge that the clock pin shows
   always_ff @(posedge LINK_CLK_I) begin
      if (link_rst) begin
         DROP_BUS_DATA_BIT5_O <= 1'b0;
         DROP_BUS_DATA_BIT6_O <= 1'b0;
      end else if (link_bus_en) begin
         DROP_BUS_DATA_BIT5_O <= DROP_BUS_DATA_CH1_I[5];
         DROP_BUS_DATA_BIT6_O <= DROP_BUS_DATA_CH1_I[6];
      end else begin
         DROP_BUS_DATA_BIT5_O <= next_line_clk[0];
         DROP_BUS_DATA_BIT6_O <= next_line_clk[1];
      end
   end

   // line data pins follow the retimers; they read low while the bus is on
   assign LINE_DATA_OUT_CH1_O = line_data[0];
   assign LINE_DATA_OUT_CH5_O = line_data[1];

endmodule // dblc_pin_mux

// file: verification/dblc_pin_mux_sva.sv
// port assertions for the drop bus pin mux
`timescale 1ns/10ps
`include "dblc_params.svh"

module dblc_pin_mux_sva #(
   parameter int ADDR_W = 18
)
(
   input wire logic              REF_CLK_I,
   input wire logic              SYS_RST_I,
   input wire logic              LINK_CLK_I,
   input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
   input wire logic              AVS_READ_I,
   input wire logic              AVS_WRITE_I,
   input wire logic [31:0]       AVS_READDATA_O,
   input wire logic              AVS_WAITREQUEST_O,
   input wire logic [1:0]        AVS_RESPONSE_O,
   input wire logic              DROP_BUS_DATA_BIT5_O,
   input wire logic              DROP_BUS_DATA_BIT6_O,
   input wire logic              LINE_DATA_OUT_CH1_O,
   input wire logic              LINE_DATA_OUT_CH5_O
);
   logic [15:0] idx;
   logic        mapped;

   // index decode, kept apart from the design's own decoder
   assign idx = 16'(AVS_ADDRESS_I[ADDR_W-1:2]);
   assign mapped = (idx <= `DBLC_IDX_STATUS) || (idx == `DBLC_IDX_IO_CTRL_CH1) ||
                   (idx == `DBLC_IDX_IO_CTRL_CH5);

   // a pending request on the register bus
   sequence s_req;
      (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
   endsequence

   req_answer_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      s_req |=> !AVS_WAITREQUEST_O) else $error("request not answered");
   wait_pulse_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      $fell(AVS_WAITREQUEST_O) |=> AVS_WAITREQUEST_O) else $error("waitrequest low too long");
   unmapped_resp_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      s_req and !mapped |=> AVS_RESPONSE_O == 2'b11 && AVS_READDATA_O == 32'h0)
      else $error("unmapped access not refused");
   upper_zero_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h0) else $error("read data upper bits");
   // line data only moves together with its clock pin
   edge_ch1_a: assert property (@(posedge LINK_CLK_I) disable iff (SYS_RST_I)
      $changed(LINE_DATA_OUT_CH1_O) |-> $changed(DROP_BUS_DATA_BIT5_O))
      else $error("ch1 data moved off a clock edge");
   edge_ch5_a: assert property (@(posedge LINK_CLK_I) disable iff (SYS_RST_I)
      $changed(LINE_DATA_OUT_CH5_O) |-> $changed(DROP_BUS_DATA_BIT6_O))
      else $error("ch5 data moved off a clock edge");
   // line data high means the bus is off, so the pin must toggle
   clock_ch1_a: assert property (@(posedge LINK_CLK_I) disable iff (SYS_RST_I)
      LINE_DATA_OUT_CH1_O [*2] |-> $changed(DROP_BUS_DATA_BIT5_O)) else $error("ch1 clock stuck");
   clock_ch5_a: assert property (@(posedge LINK_CLK_I) disable iff (SYS_RST_I)
      LINE_DATA_OUT_CH5_O [*2] |-> $changed(DROP_BUS_DATA_BIT6_O)) else $error("ch5 clock stuck");
endmodule // dblc_pin_mux_sva

// file: verification/dblc_liu_model.sv
// line interface receiver model: sorts data changes by clock edge
`timescale 1ns/10ps

module dblc_liu_model (
   input  wire logic       link_clk_i,
   input  wire logic       clr_i,
   input  wire logic       tx_clock_i,
   input  wire logic       tx_data_i,
   output logic      [7:0] n_rise_o,
   output logic      [7:0] n_fall_o
);
   logic last_data;

   // clock level after a data change tells which edge launched it
   always_ff @(posedge link_clk_i) begin
      last_data <= tx_data_i;
      if (clr_i) begin
         n_rise_o <= 8'h00;
         n_fall_o <= 8'h00;
      end else if (tx_data_i != last_data) begin
         if (tx_clock_i)
            n_rise_o <= n_rise_o + 8'h01;
         else
            n_fall_o <= n_fall_o + 8'h01;
      end
   end
endmodule // dblc_liu_model

// file: verification/tb_drop_bus_line_clock_pin_mux.sv
// self-checking bench for the drop bus pin mux
`timescale 1ns/10ps
`include "dblc_params.svh"

module tb_drop_bus_line_clock_pin_mux
   import dblc_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        link_clk = 1'b0;
   logic        rst = 1'b1;
   logic [17:0] addr = 18'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  be = 4'hf;
   logic [31:0] rdata;
   logic        waitreq;
   logic [1:0]  resp;
   logic [7:0]  byte_in = 8'h00;
   logic        ld1 = 1'b0;
   logic        ld5 = 1'b0;
   logic        pin5, pin6, lo1, lo5;
   logic        clr = 1'b1;
   logic [7:0]  r1, f1, r5, f5;
   int          n_mismatch = 0;
   int          total_checks = 0;

   // edges of the two clocks coincide every 150 ns
   always #50 ref_clk = ~ref_clk;
   always #15 link_clk = ~link_clk;

   dblc_pin_mux dut (.REF_CLK_I(ref_clk), .SYS_RST_I(rst), .LINK_CLK_I(link_clk),
      .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
      .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
      .AVS_RESPONSE_O(resp), .DROP_BUS_DATA_CH1_I(byte_in), .LINE_DATA_CH1_I(ld1),
      .LINE_DATA_CH5_I(ld5), .DROP_BUS_DATA_BIT5_O(pin5), .DROP_BUS_DATA_BIT6_O(pin6),
      .LINE_DATA_OUT_CH1_O(lo1), .LINE_DATA_OUT_CH5_O(lo5));
   dblc_liu_model liu1 (.link_clk_i(link_clk), .clr_i(clr), .tx_clock_i(pin5),
      .tx_data_i(lo1), .n_rise_o(r1), .n_fall_o(f1));
   dblc_liu_model liu5 (.link_clk_i(link_clk), .clr_i(clr), .tx_clock_i(pin6),
      .tx_data_i(lo5), .n_rise_o(r5), .n_fall_o(f5));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic wait_ref(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // one register access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
                      input logic [1:0] er, input logic [7:0] ed);
      int n;
      n = 0;
      @(posedge ref_clk);
      addr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      rd <= !w;
      wr <= w;
      do begin
         @(posedge ref_clk);
         n++;
      end while (waitreq !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
      chk("bus answer", 32'd2, n);
      chk("response", {30'h0, er}, {30'h0, resp});
      if (!w)
         chk("read data", {24'h0, ed}, rdata);
   endtask

   task automatic t_regs;
      bus(0, `DBLC_IDX_IO_CTRL_CH1, 8'h00, 2'b00, 8'h00);
      bus(0, `DBLC_IDX_IO_CTRL_CH5, 8'h00, 2'b00, 8'h00);
      bus(1, `DBLC_IDX_IO_CTRL_CH1, 8'h5b, 2'b00, 8'h00);
      bus(1, `DBLC_IDX_IND_PAGE, `DBLC_PAGE_CH1, 2'b00, 8'h00);
      bus(1, `DBLC_IDX_IND_OFFSET, `DBLC_PAGE_OFS_IO, 2'b00, 8'h00);
      bus(0, `DBLC_IDX_IND_DATA, 8'h00, 2'b00, 8'h5b);
      bus(1, `DBLC_IDX_IND_DATA, 8'ha4, 2'b00, 8'h00);
      bus(0, `DBLC_IDX_IO_CTRL_CH1, 8'h00, 2'b00, 8'ha4);
      bus(1, `DBLC_IDX_IND_PAGE, `DBLC_PAGE_CH5, 2'b00, 8'h00);
      bus(1, `DBLC_IDX_IND_DATA, 8'h3c, 2'b00, 8'h00);
      bus(0, `DBLC_IDX_IO_CTRL_CH5, 8'h00, 2'b00, 8'h3c);
      be <= 4'he;
      bus(1, `DBLC_IDX_IO_CTRL_CH5, 8'hff, 2'b00, 8'h00);
      be <= 4'hf;
      bus(0, `DBLC_IDX_IO_CTRL_CH5, 8'h00, 2'b00, 8'h3c);
      bus(1, `DBLC_IDX_IND_PAGE, 8'h2f, 2'b00, 8'h00);
      bus(0, `DBLC_IDX_IND_DATA, 8'h00, 2'b11, 8'h00);
      bus(1, 16'h0123, 8'hff, 2'b11, 8'h00);
      bus(0, 16'h0123, 8'h00, 2'b11, 8'h00);
   endtask

   // six slow line bit toggles, then count launch edges per channel
   task automatic t_line(input logic [3:0] mode, input logic i1, input logic i5,
                         input logic e1, input logic e5);
      bus(1, `DBLC_IDX_LINE_MODE, {4'h0, mode}, 2'b00, 8'h00);
      bus(1, `DBLC_IDX_IO_CTRL_CH1, {7'h0, i1}, 2'b00, 8'h00);
      bus(1, `DBLC_IDX_IO_CTRL_CH5, {7'h0, i5}, 2'b00, 8'h00);
      clr <= 1'b1;
      wait_ref(4);
      clr <= 1'b0;
      repeat (6) begin
         ld1 <= ~ld1;
         ld5 <= ~ld5;
         wait_ref(4);
      end
      chk("ch1 rise launches", e1 ? 32'd6 : 32'd0, {24'h0, r1});
      chk("ch1 fall launches", e1 ? 32'd0 : 32'd6, {24'h0, f1});
      chk("ch5 rise launches", e5 ? 32'd6 : 32'd0, {24'h0, r5});
      chk("ch5 fall launches", e5 ? 32'd0 : 32'd6, {24'h0, f5});
   endtask

   task automatic t_bus;
      logic [7:0] pat [4] = '{8'h20, 8'h40, 8'h80, 8'hdf};
      bus(1, `DBLC_IDX_BUS_CTRL, 8'h01, 2'b00, 8'h00);
      foreach (pat[i]) begin
         byte_in <= pat[i];
         wait_ref(3);
         chk("bit5 pin", {31'h0, pat[i][5]}, {31'h0, pin5});
         chk("bit6 pin", {31'h0, pat[i][6]}, {31'h0, pin6});
         chk("ch1 line data", 32'h0, {31'h0, lo1});
         chk("ch5 line data", 32'h0, {31'h0, lo5});
      end
      bus(0, `DBLC_IDX_STATUS, 8'h00, 2'b00, 8'h05);
      bus(1, `DBLC_IDX_BUS_CTRL, 8'h00, 2'b00, 8'h00);
   endtask

   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      t_line(4'h0, 1'b0, 1'b0, 1'b1, 1'b1);
      t_line({DBLC_MODE_STS1, DBLC_MODE_E3}, 1'b1, 1'b1, 1'b0, 1'b1);
      t_line({DBLC_MODE_DS3, DBLC_MODE_STS1}, 1'b1, 1'b1, 1'b1, 1'b0);
      t_bus();
      t_line(4'h0, 1'b0, 1'b0, 1'b1, 1'b1);
      wrap_up();
   end

   // run needs about 23 us; cut off well past that
   initial begin
      #200000;
      n_mismatch++;
      wrap_up();
   end
endmodule // tb_drop_bus_line_clock_pin_mux

bind dblc_pin_mux dblc_pin_mux_sva #(.ADDR_W(ADDR_W)) u_sva (.REF_CLK_I(REF_CLK_I),
   .SYS_RST_I(SYS_RST_I), .LINK_CLK_I(LINK_CLK_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
   .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
   .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .AVS_RESPONSE_O(AVS_RESPONSE_O),
   .DROP_BUS_DATA_BIT5_O(DROP_BUS_DATA_BIT5_O), .DROP_BUS_DATA_BIT6_O(DROP_BUS_DATA_BIT6_O),
   .LINE_DATA_OUT_CH1_O(LINE_DATA_OUT_CH1_O), .LINE_DATA_OUT_CH5_O(LINE_DATA_OUT_CH5_O));
